// ### include/gsct_defs.svh
`ifndef GSCT_DEFS_SVH
`define GSCT_DEFS_SVH

// write latency range, in link clock cycles
`define GSCT_WL_MIN 3'h1
`define GSCT_WL_MAX 3'h6
`define GSCT_WL_RST 3'h6
// last latency that opens the input buffers at activate
`define GSCT_WL_EARLY_MAX 3'h3
// burst of four beats on both strobe edges spans two link cycles
`define GSCT_BURST_LINK 5'h02
// last data beat to internal precharge for a self-closing write
`define GSCT_WR_AUTO_LINK 5'h07
`define GSCT_CNT_ZERO 5'h00
`define GSCT_CNT_ONE 5'h01
// age counters saturate here rather than wrap back to a small value
`define GSCT_CNT_MAX 5'h1f
`define GSCT_BANKS 4
// command pin pattern {cs_n, ras_n, cas_n, we_n}
`define GSCT_CMD_MODE 4'h0
`define GSCT_CMD_ACT 4'h3
`define GSCT_CMD_WRITE 4'h4
`define GSCT_CMD_PRE 4'h2

`endif

// ### include/gsct_pkg.sv
package gsct_pkg;

  // command and address pins as sampled on a link clock rise
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic a10;
    logic [1:0] bank;
    logic [2:0] addr;
  } gsct_cmd_t;

  // input buffer control states
  typedef enum logic [2:0] {
    GSCT_BUF_OFF = 3'h1,
    GSCT_BUF_ROW = 3'h2,
    GSCT_BUF_WR = 3'h4
  } gsct_buf_t;

endpackage : gsct_pkg

// ### logic/gsct_cmd_timing.sv
`timescale 1ns/1ps
`include "gsct_defs.svh"
module gsct_cmd_timing (
  input wire logic mclk_i, // 250 MHz core clock
  input wire logic srst_i, // synchronous reset, active high
  input wire logic link_ck_i, // command clock from the controller
  input wire gsct_pkg::gsct_cmd_t cmd_i, // command and address pins
  output logic inbuf_en_o, // data input buffers switched on
  output logic [2:0] wl_o, // write delay setting in force
  output logic [3:0] bank_open_o, // rows open per bank
  output logic [3:0] auto_pre_o // internal precharge pulse per bank
);

  gsct_pkg::gsct_cmd_t cmd_s1_r;
  gsct_pkg::gsct_cmd_t cmd_s2_r;
  logic ck_s1_r;
  logic ck_s2_r;
  logic ck_s3_r;
  logic edge_w;
  logic [3:0] code_w;
  logic is_mode_w;
  logic is_act_w;
  logic is_write_w;
  logic is_pre_w;
  logic [2:0] wl_r;
  logic [3:0] bank_open_r;
  logic [4:0] wr_cnt_r;
  logic [4:0] ap_load_w;
  logic [4:0] wr_load_w;
  gsct_pkg::gsct_buf_t buf_r;
  logic inbuf_en_r;
  logic [3:0] auto_pre_r;

  // two flops on every pin before anything looks at it
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cmd_s1_r <= '1;
      cmd_s2_r <= '1;
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      ck_s3_r <= 1'b0;
    end else begin
      cmd_s1_r <= cmd_i;
      cmd_s2_r <= cmd_s1_r;
      ck_s1_r <= link_ck_i;
      ck_s2_r <= ck_s1_r;
      ck_s3_r <= ck_s2_r;
    end
  end

  // pins are sampled on the rise of the link clock, as seen in the core
  // clock; the 125 ns link period leaves pins settled well before that
  assign edge_w = ck_s2_r & ~ck_s3_r;
  assign code_w = {cmd_s2_r.cs_n, cmd_s2_r.ras_n, cmd_s2_r.cas_n, cmd_s2_r.we_n};
  assign is_mode_w = edge_w && (code_w == `GSCT_CMD_MODE);
  assign is_act_w = edge_w && (code_w == `GSCT_CMD_ACT);
  assign is_write_w = edge_w && (code_w == `GSCT_CMD_WRITE);
  assign is_pre_w = edge_w && (code_w == `GSCT_CMD_PRE);
  assign wr_load_w = {2'b00, wl_r} + `GSCT_BURST_LINK;
  assign ap_load_w = wr_load_w + `GSCT_WR_AUTO_LINK;

  // write delay setting; out-of-range values leave the old one in force
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wl_r <= `GSCT_WL_RST;
    end else if (is_mode_w && cmd_s2_r.addr >= `GSCT_WL_MIN
                 && cmd_s2_r.addr <= `GSCT_WL_MAX) begin
      wl_r <= cmd_s2_r.addr;
    end
  end

  // open rows; a precharge with a10 high closes every bank
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      bank_open_r <= 4'h0;
    end else begin
      if (is_act_w) begin
        bank_open_r[cmd_s2_r.bank] <= 1'b1;
      end else if (is_pre_w && cmd_s2_r.a10) begin
        bank_open_r <= 4'h0;
      end else if (is_pre_w) begin
        bank_open_r[cmd_s2_r.bank] <= 1'b0;
      end else begin
        bank_open_r <= bank_open_r & ~auto_pre_r;
      end
    end
  end

  // link cycles until the last beat of the latest write has landed
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wr_cnt_r <= `GSCT_CNT_ZERO;
    end else if (is_write_w) begin
      wr_cnt_r <= wr_load_w;
    end else if (edge_w && wr_cnt_r != `GSCT_CNT_ZERO) begin
      wr_cnt_r <= wr_cnt_r - `GSCT_CNT_ONE;
    end
  end

  // input buffer control: early opening costs power but hides the
  // buffer wake-up behind the activate-to-write gap
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      buf_r <= gsct_pkg::GSCT_BUF_OFF;
    end else begin
      case (buf_r)
        gsct_pkg::GSCT_BUF_OFF: begin
          if (is_act_w && wl_r <= `GSCT_WL_EARLY_MAX) begin
            buf_r <= gsct_pkg::GSCT_BUF_ROW;
          end else if (is_write_w) begin
            buf_r <= gsct_pkg::GSCT_BUF_WR;
          end
        end
        gsct_pkg::GSCT_BUF_ROW: begin
          // stays on while a row is open or a burst is still landing
          if (bank_open_r == 4'h0 && wr_cnt_r == `GSCT_CNT_ZERO && !is_write_w
              && !is_act_w) begin
            buf_r <= gsct_pkg::GSCT_BUF_OFF;
          end
        end
        gsct_pkg::GSCT_BUF_WR: begin
          if (is_act_w && wl_r <= `GSCT_WL_EARLY_MAX) begin
            buf_r <= gsct_pkg::GSCT_BUF_ROW;
          end else if (edge_w && wr_cnt_r == `GSCT_CNT_ONE && !is_write_w) begin
            // a write landing on the last beat of the previous one keeps them on
            buf_r <= gsct_pkg::GSCT_BUF_OFF;
          end
        end
        default: begin
          buf_r <= gsct_pkg::GSCT_BUF_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      inbuf_en_r <= 1'b0;
    end else begin
      inbuf_en_r <= (buf_r != gsct_pkg::GSCT_BUF_OFF);
    end
  end

  // per-bank recovery timer for self-closing writes; a new self-closing write to the
  // same bank restarts it, so only the last one precharges unless the new write comes on the edge where the count is at one
  genvar gb;
  generate
    for (gb = 0; gb < `GSCT_BANKS; gb = gb + 1) begin : g_bank
      logic [4:0] ap_cnt_r;
      always_ff @(posedge mclk_i) begin
        if (srst_i) begin
          ap_cnt_r <= `GSCT_CNT_ZERO;
          auto_pre_r[gb] <= 1'b0;
        end else begin
          auto_pre_r[gb] <= edge_w && ap_cnt_r == `GSCT_CNT_ONE;
          if (is_write_w && cmd_s2_r.a10 && cmd_s2_r.bank == 2'(gb)) begin
            ap_cnt_r <= ap_load_w;
          end else if (edge_w && ap_cnt_r != `GSCT_CNT_ZERO) begin
            ap_cnt_r <= ap_cnt_r - `GSCT_CNT_ONE;
          end
        end
      end
    end
  endgenerate

  assign inbuf_en_o = inbuf_en_r;
  assign wl_o = wl_r;
  assign bank_open_o = bank_open_r;
  assign auto_pre_o = auto_pre_r;

  // helper: link edges since the last self-closing write to bank 0
  logic [4:0] ap_age0_r;
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ap_age0_r <= `GSCT_CNT_ZERO;
    end else if (is_write_w && cmd_s2_r.a10 && cmd_s2_r.bank == 2'h0) begin
      ap_age0_r <= `GSCT_CNT_ZERO;
    end else if (edge_w && ap_age0_r != `GSCT_CNT_MAX) begin
      ap_age0_r <= ap_age0_r + `GSCT_CNT_ONE;
    end
  end

  property p_wl_range;
    @(posedge mclk_i) disable iff (srst_i)
    wl_o >= `GSCT_WL_MIN && wl_o <= `GSCT_WL_MAX;
  endproperty
  a_wl_range: assert property (p_wl_range) else $error("write delay out of range");

  property p_wl_take;
    @(posedge mclk_i) disable iff (srst_i)
    is_mode_w && cmd_s2_r.addr >= `GSCT_WL_MIN && cmd_s2_r.addr <= `GSCT_WL_MAX
      |=> wl_o == $past(cmd_s2_r.addr);
  endproperty
  a_wl_take: assert property (p_wl_take) else $error("write delay not taken");

  sequence s_early_act;
    is_act_w && wl_r <= `GSCT_WL_EARLY_MAX;
  endsequence
  property p_buf_act;
    @(posedge mclk_i) disable iff (srst_i)
    s_early_act |-> ##2 inbuf_en_o;
  endproperty
  a_buf_act: assert property (p_buf_act) else $error("buffers not on at activate");

  property p_buf_late;
    @(posedge mclk_i) disable iff (srst_i)
    is_act_w && wl_r > `GSCT_WL_EARLY_MAX && !inbuf_en_o && buf_r == gsct_pkg::GSCT_BUF_OFF
      |-> ##2 !inbuf_en_o;
  endproperty
  a_buf_late: assert property (p_buf_late) else $error("buffers on at activate");

  property p_buf_wr;
    @(posedge mclk_i) disable iff (srst_i)
    is_write_w |-> ##2 inbuf_en_o;
  endproperty
  a_buf_wr: assert property (p_buf_wr) else $error("buffers off at write");

  property p_ap_time;
    @(posedge mclk_i) disable iff (srst_i)
    $rose(auto_pre_o[0]) |-> ap_age0_r == ap_load_w;
  endproperty
  a_ap_time: assert property (p_ap_time) else $error("auto precharge mistimed");

endmodule : gsct_cmd_timing

// ### dv/gsct_ctrl_model.sv
`timescale 1ns/1ps
// controller stand-in: one command per link clock rise, clock stands still between
module gsct_ctrl_model (
  output logic link_ck_o, // command clock, low while idle
  output gsct_pkg::gsct_cmd_t cmd_o // command and address pins
);
  initial begin
    link_ck_o = 1'b0;
    cmd_o = 10'h3ff;
  end
  // pins settle a quarter period before the rise and hold a quarter period after it;
  // no pin changes twice in one time step, even between back-to-back sends
  // only mode set, activate, write, precharge and deselect are sent: no strobe,
  // refresh, read or self refresh, so the gaps around those hold trivially
  task send(input gsct_pkg::gsct_cmd_t c);
    begin
      #31.25 cmd_o = c;
      #31.25 link_ck_o = 1'b1;
      #31.25 cmd_o = {1'b1, ~c[8:0]}; // deselected, other pins flip so no stale value lingers
      #31.25 link_ck_o = 1'b0;
    end
  endtask : send
endmodule : gsct_ctrl_model

// ### dv/test_graphics_sdram_command_timing.sv
`timescale 1ns/1ps
`include "gsct_defs.svh"
module test_graphics_sdram_command_timing;
  logic mclk_i;
  logic srst_i;
  logic link_ck_i;
  gsct_pkg::gsct_cmd_t cmd_i;
  logic inbuf_en_o;
  logic [2:0] wl_o;
  logic [3:0] bank_open_o;
  logic [3:0] auto_pre_o;
  logic [3:0] seen = 4'h0;
  logic [3:0] mopen;
  int errors = 0;
  int check_count = 0;
  int mwl;
  int w;
  int bk;
  int unsigned rs = 18244;

  gsct_ctrl_model P (.link_ck_o(link_ck_i), .cmd_o(cmd_i));
  gsct_cmd_timing DUT (.mclk_i(mclk_i), .srst_i(srst_i), .link_ck_i(link_ck_i),
    .cmd_i(cmd_i), .inbuf_en_o(inbuf_en_o), .wl_o(wl_o), .bank_open_o(bank_open_o),
    .auto_pre_o(auto_pre_o));

  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  // precharge pulses last one cycle, so collect them
  always @(posedge mclk_i) seen = seen | auto_pre_o;

  function automatic int rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return int'(rs & 32'h7fffffff);
  endfunction : rnd

  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task cmd(input logic [3:0] code, input logic a10, input int b, input int ad);
    P.send({code, a10, 2'(b), 3'(ad)});
  endtask : cmd

  // deselect cycles keep the link clock running for burst and recovery counts
  task gap(input int n);
    repeat (n) P.send(10'h3ff);
  endtask : gap

  task state();
    chk({5'h0, wl_o}, 8'(mwl));
    chk({4'h0, bank_open_o}, {4'h0, mopen});
  endtask : state

  task close_out();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  // cuts a hang short
  initial begin
    #200000;
    errors++;
    close_out();
  end

  initial begin
    srst_i = 1'b1;
    repeat (8) @(posedge mclk_i);
    #1 srst_i = 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
    mwl = 6;
    mopen = 4'h0;
    state();
    chk({7'h0, inbuf_en_o}, 8'h00);
    $display("test reset done");
    // every setting code, the two out of range ones must be ignored
    for (int i = 0; i < 8; i++) begin
      cmd(`GSCT_CMD_MODE, 1'b0, 0, i);
      if (i >= 1 && i <= 6) mwl = i;
      state();
      gap(6);
    end
    $display("test write delay setting done");
    // first pass short delay, second pass long delay
    for (int p = 0; p < 2; p++) begin
      w = (p == 1) ? 4 + rnd() % 3 : 1 + rnd() % 3;
      // pass 0 uses bank 0 so the bank 0 recovery-age check is exercised
      bk = (p == 0) ? 0 : rnd() % 4;
      cmd(`GSCT_CMD_MODE, 1'b0, 0, w);
      mwl = w;
      gap(6);
      cmd(`GSCT_CMD_ACT, 1'b0, bk, 0);
      mopen[bk] = 1'b1;
      state();
      chk({7'h0, inbuf_en_o}, (w <= 3) ? 8'h01 : 8'h00);
      gap(6);
      seen = 4'h0;
      cmd(`GSCT_CMD_WRITE, 1'b1, bk, 0);
      chk({7'h0, inbuf_en_o}, 8'h01);
      gap(w + 8);
      chk({4'h0, seen}, 8'h00);
      gap(1);
      chk({4'h0, seen}, 8'(1 << bk));
      mopen[bk] = 1'b0;
      state();
      chk({7'h0, inbuf_en_o}, 8'h00);
      gap(18);
      // two rows open, later closed by a single-bank precharge and then one with a10 high
      cmd(`GSCT_CMD_ACT, 1'b0, bk ^ 1, 0);
      gap(8);
      cmd(`GSCT_CMD_ACT, 1'b0, bk, 0);
      mopen[bk] = 1'b1;
      mopen[bk ^ 1] = 1'b1;
      state();
      chk({7'h0, inbuf_en_o}, (w <= 3) ? 8'h01 : 8'h00);
      // plain write: buffers open, but no internal precharge follows
      gap(6);
      seen = 4'h0;
      cmd(`GSCT_CMD_WRITE, 1'b0, bk, 0);
      chk({7'h0, inbuf_en_o}, 8'h01);
      gap(w + 9);
      chk({4'h0, seen}, 8'h00);
      state();
      gap(9);
      // close one bank alone, then the rest with a10 high
      cmd(`GSCT_CMD_PRE, 1'b0, bk ^ 1, 0);
      mopen[bk ^ 1] = 1'b0;
      state();
      cmd(`GSCT_CMD_PRE, 1'b1, 0, 0);
      mopen = 4'h0;
      state();
      chk({7'h0, inbuf_en_o}, 8'h00);
      gap(9);
      $display("test pass %0d with delay %0d done", p, w);
    end
    // mid-run reset with a row open and a short delay in force
    cmd(`GSCT_CMD_MODE, 1'b0, 0, 2);
    gap(6);
    cmd(`GSCT_CMD_ACT, 1'b0, 2, 0);
    mwl = 2;
    mopen = 4'h4;
    state();
    chk({7'h0, inbuf_en_o}, 8'h01);
    @(posedge mclk_i);
    #1 srst_i = 1'b1;
    repeat (8) @(posedge mclk_i);
    #1 srst_i = 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
    mwl = 6;
    mopen = 4'h0;
    state();
    chk({7'h0, inbuf_en_o}, 8'h00);
    $display("test mid-run reset done");
    close_out();
  end
endmodule : test_graphics_sdram_command_timing
